// >>> rtl/flash_cmd_core.sv
// Purpose: Instruction interpreter: erase, deep sleep and identity reads
// Assumes: SPI link on its own clock; synchronous active-high reset
// Notes: Array contents modelled as erase events on output ports
//
// Summary of operation
// - Block erase drives every byte of the chosen block to all ones.
// - Erase needs write-unlock first; unlock sets latch, erase checks it.
// - Block erase runs only if select rises right after bit eight.
// - Valid block erase starts timed cycle; busy flag high throughout.
// - Write-enable latch clears before each erase cycle completes.
// - Block erase on a protected area is dropped, array untouched.
// - Chip erase drives every byte of the array to all ones.
// - Chip erase runs only if select rises right after bit eight.
// - Valid chip erase starts timed cycle; busy flag high throughout.
// - Chip erase runs only with all three protect bits zero.
// - Deselect gives standby; only the sleep command enters deep sleep.
// - In deep sleep only the wake command acts and releases the device.
// - Reset always leaves the device in standby, not deep sleep.
// - Sleep command needs exact bit-eight rise; entry after a delay.
// - Sleep command during a running cycle is rejected harmlessly.
// - Long identity read shifts maker, type, capacity on falling edges.
// - Long identity read during a cycle is not decoded.
// - Raising select during identity output returns to standby.
// - Short identity: opcode, two dummies, address, then two bytes.
// - Address one sends device byte first; zero sends maker first.
// - Short identity read during a cycle is not decoded.
// - Wake command takes three dummies then repeats the signature.
// - Wake from deep sleep returns to standby after a wake delay.
`timescale 1ns/100ps
module flash_cmd_core #(
	parameter int BLOCK_ERASE_CYCLES = flash_cmd_pkg::BLOCK_ERASE_CYC,
	parameter int CHIP_ERASE_CYCLES = flash_cmd_pkg::CHIP_ERASE_CYC,
	parameter int SLEEP_CYCLES = flash_cmd_pkg::SLEEP_ENTRY_CYC,
	parameter int WAKE_CYCLES = flash_cmd_pkg::WAKE_CYC
) (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic SCLK_IN,
	input wire logic CS_N_IN,
	input wire logic SERIAL_IN_LINE_IN,
	input wire logic [2:0] PROTECT_FIELD_IN,
	output logic SERIAL_OUT_OUT,
	output logic SERIAL_OUT_OE_OUT,
	output logic WRITE_ENABLE_LATCH_OUT,
	output logic WRITE_IN_PROGRESS_FLAG_OUT,
	output logic DEEP_SLEEP_OUT,
	output logic BLOCK_ERASE_DONE_OUT,
	output logic CHIP_ERASE_DONE_OUT
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_BLOCK = 6'b000010,
		ST_CHIP = 6'b000100,
		ST_GO_SLEEP = 6'b001000,
		ST_SLEEP = 6'b010000,
		ST_WAKE = 6'b100000
	} mode_e;

	link_if lk ();
	logic miso_w, miso_oe_w;

	// Link-clock logic; its outputs cross to this domain below
	spi_link_side u_link (
		.sclk_in(SCLK_IN),
		.cs_n_in(CS_N_IN),
		.mosi_in(SERIAL_IN_LINE_IN),
		.lk(lk),
		.miso_out(miso_w),
		.miso_oe_out(miso_oe_w)
	);

	// ----------------------------------------------------------------
	// Crossing
	// ----------------------------------------------------------------
	logic [2:0] tgl_q;
	logic [2:0] prot_s1_q, prot_s2_q, prot_q;
	logic busy_lvl_q, sleep_lvl_q;
	logic frame_end;
	// Busy and sleep go to the link as levels; link reads busy from the last stage
	always_ff @(posedge SCLK_IN or posedge CS_N_IN) begin
		if (CS_N_IN) begin
			lk.busy_sync <= 3'h0;
		end else begin
			lk.busy_sync <= {lk.busy_sync[1:0], busy_lvl_q};
		end
	end
	// Sleep only changes between frames, so its level is steady in frames
	assign lk.sleep_lvl = sleep_lvl_q;

	// Toggle keeps shifting through reset so no false edge follows it
	always_ff @(posedge CLOCK_IN) begin
		tgl_q <= {tgl_q[1:0], lk.end_tgl};
	end
	// Protect field filtered; a change counts once two stages agree
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			prot_s1_q <= 3'h0;
			prot_s2_q <= 3'h0;
			prot_q <= flash_cmd_pkg::PROTECT_RESET;
		end else begin
			prot_s1_q <= PROTECT_FIELD_IN;
			prot_s2_q <= prot_s1_q;
			if (prot_s2_q == prot_s1_q) prot_q <= prot_s2_q;
		end
	end
	assign frame_end = !RST_IN && (tgl_q[2] ^ tgl_q[1]);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Protected when any protect bit set; whole-array block in this part
	function automatic logic covers(input logic [2:0] field);
		covers = (field != 3'h0);
	endfunction

	mode_e mode_q, mode_d;
	logic [31:0] cnt_q, cnt_d;
	logic wel_q, wel_d;
	logic blk_done_q, chip_done_q;
	logic exact, unlock_ok, blk_ok, chip_ok, sleep_ok, wake_ok;
	logic [7:0] op;
	assign op = lk.end_op;
	assign exact = frame_end && lk.end_exact;
	assign unlock_ok = exact && mode_q == ST_IDLE
		&& op == flash_cmd_pkg::WRITE_UNLOCK_OP;
	assign blk_ok = exact && mode_q == ST_IDLE && wel_q
		&& op == flash_cmd_pkg::BLOCK_ERASE_OP
		&& !covers(prot_q);
	assign chip_ok = exact && mode_q == ST_IDLE && wel_q
		&& op == flash_cmd_pkg::CHIP_ERASE_OP
		&& prot_q == 3'h0;
	assign sleep_ok = exact && mode_q == ST_IDLE
		&& op == flash_cmd_pkg::DEEP_SLEEP_OP;
	// Wake checks no frame length; any frame whose captured opcode is the wake code acts
	assign wake_ok = frame_end && mode_q == ST_SLEEP
		&& op == flash_cmd_pkg::WAKE_SIG_OP;

	// ----------------------------------------------------------------
	// Mode machine
	// ----------------------------------------------------------------
	always_comb begin
		mode_d = mode_q;
		cnt_d = (cnt_q != 32'h0) ? cnt_q - 32'h1 : 32'h0;
		wel_d = wel_q;
		case (mode_q)
			ST_IDLE: begin
				if (unlock_ok) wel_d = 1'b1;
				if (blk_ok) begin
					mode_d = ST_BLOCK;
					cnt_d = 32'(BLOCK_ERASE_CYCLES);
				end else if (chip_ok) begin
					mode_d = ST_CHIP;
					cnt_d = 32'(CHIP_ERASE_CYCLES);
				end else if (sleep_ok) begin
					mode_d = ST_GO_SLEEP;
					cnt_d = 32'(SLEEP_CYCLES);
				end
			end
			ST_BLOCK, ST_CHIP: begin
				// Latch drops early so it is clear before busy falls
				if (cnt_q <= 32'(flash_cmd_pkg::WEL_CLEAR_CYC))
					wel_d = 1'b0;
				if (cnt_q == 32'h1) mode_d = ST_IDLE;
			end
			ST_GO_SLEEP: begin
				if (cnt_q == 32'h1) mode_d = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (wake_ok) begin
					mode_d = ST_WAKE;
					cnt_d = 32'(WAKE_CYCLES);
				end
			end
			ST_WAKE: begin
				if (cnt_q == 32'h1) mode_d = ST_IDLE;
			end
			default: mode_d = ST_IDLE;
		endcase
	end

	// Reset always lands in standby with the latch clear
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			mode_q <= ST_IDLE;
			cnt_q <= 32'h0;
			wel_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			cnt_q <= cnt_d;
			wel_q <= wel_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Done pulses stand for the array being set to all ones
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			busy_lvl_q <= 1'b0;
			sleep_lvl_q <= 1'b0;
			blk_done_q <= 1'b0;
			chip_done_q <= 1'b0;
			WRITE_ENABLE_LATCH_OUT <= 1'b0;
			WRITE_IN_PROGRESS_FLAG_OUT <= 1'b0;
			DEEP_SLEEP_OUT <= 1'b0;
			SERIAL_OUT_OUT <= 1'b0;
			SERIAL_OUT_OE_OUT <= 1'b0;
		end else begin
			busy_lvl_q <= (mode_d == ST_BLOCK || mode_d == ST_CHIP);
			sleep_lvl_q <= (mode_d == ST_SLEEP);
			blk_done_q <= (mode_q == ST_BLOCK && cnt_q == 32'h1);
			chip_done_q <= (mode_q == ST_CHIP && cnt_q == 32'h1);
			WRITE_ENABLE_LATCH_OUT <= wel_d;
			WRITE_IN_PROGRESS_FLAG_OUT <= (mode_d == ST_BLOCK
				|| mode_d == ST_CHIP);
			// Still asleep until the wake delay has run out
			DEEP_SLEEP_OUT <= (mode_d == ST_SLEEP
				|| mode_d == ST_WAKE);
			SERIAL_OUT_OUT <= miso_w;
			SERIAL_OUT_OE_OUT <= miso_oe_w;
		end
	end
	assign BLOCK_ERASE_DONE_OUT = blk_done_q;
	assign CHIP_ERASE_DONE_OUT = chip_done_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_ERASE_NEEDS_WEL: assert property (@(posedge CLOCK_IN)
		disable iff (RST_IN) (blk_ok || chip_ok) |-> wel_q)
		else $error("erase started without latch");
	AST_BLOCK_BUSY: assert property (@(posedge CLOCK_IN)
		disable iff (RST_IN) blk_ok |=> ##1 WRITE_IN_PROGRESS_FLAG_OUT)
		else $error("block erase not busy");
	AST_WEL_CLEARED: assert property (@(posedge CLOCK_IN)
		disable iff (RST_IN)
		$fell(WRITE_IN_PROGRESS_FLAG_OUT) |-> !WRITE_ENABLE_LATCH_OUT)
		else $error("latch set when cycle ended");
	AST_PROTECT_BLOCK: assert property (@(posedge CLOCK_IN)
		disable iff (RST_IN) blk_ok |-> prot_q == 3'h0)
		else $error("protected block erased");
	AST_CHIP_PROT: assert property (@(posedge CLOCK_IN)
		disable iff (RST_IN) (mode_q == ST_IDLE && mode_d == ST_CHIP)
		|-> prot_q == 3'h0) else $error("protected chip erased");
	AST_NO_SLEEP_BUSY: assert property (@(posedge CLOCK_IN)
		disable iff (RST_IN) ((mode_q == ST_BLOCK || mode_q == ST_CHIP)
		&& frame_end) |=> mode_q != ST_GO_SLEEP)
		else $error("sleep during cycle");
	AST_SLEEP_ONLY_WAKE: assert property (@(posedge CLOCK_IN)
		disable iff (RST_IN) (mode_q == ST_SLEEP && !wake_ok)
		|=> mode_q == ST_SLEEP) else $error("left sleep without wake");
	AST_SLEEP_ENTRY: assert property (@(posedge CLOCK_IN)
		disable iff (RST_IN) (mode_q != ST_SLEEP && mode_d == ST_SLEEP)
		|-> mode_q == ST_GO_SLEEP) else $error("sleep by other path");
endmodule

// >>> rtl/flash_cmd_pkg.sv
// Purpose: Shared constants for the serial flash instruction logic
// Assumes: 50 MHz system clock
// Notes: Opcodes, identity bytes and durations are configurable constants
package flash_cmd_pkg;
	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] WRITE_UNLOCK_OP = 8'h06;
	localparam logic [7:0] BLOCK_ERASE_OP = 8'hD8;
	localparam logic [7:0] CHIP_ERASE_OP = 8'hC7;
	localparam logic [7:0] DEEP_SLEEP_OP = 8'hB9;
	localparam logic [7:0] WAKE_SIG_OP = 8'hAB;
	localparam logic [7:0] READ_IDENTITY_ALIAS_OP = 8'h9F;
	localparam logic [7:0] READ_SHORT_ID_OP = 8'h90;
	// ----------------------------------------------------------------
	// Identity values (arbitrary neutral values)
	// ----------------------------------------------------------------
	localparam logic [7:0] MAKER_BYTE = 8'h5A;
	localparam logic [7:0] MEM_TYPE_BYTE = 8'h41;
	localparam logic [7:0] CAPACITY_BYTE = 8'h11;
	localparam logic [7:0] SHORT_DEV_BYTE = 8'h0E;
	localparam logic [7:0] SIGNATURE_BYTE = 8'h0E;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int BLOCK_ERASE_TIME_US = 500000;
	localparam int CHIP_ERASE_TIME_US = 1000000;
	localparam int SLEEP_ENTRY_DELAY_US = 3;
	localparam int WAKE_DELAY_US = 3;
	localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * CLK_MHZ;
	localparam int CHIP_ERASE_CYC = CHIP_ERASE_TIME_US * CLK_MHZ;
	localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_DELAY_US * CLK_MHZ;
	localparam int WAKE_CYC = WAKE_DELAY_US * CLK_MHZ;
	localparam int WEL_CLEAR_CYC = 4;
	localparam logic [2:0] PROTECT_RESET = 3'h0;
	localparam int PROTECT_MASK_BITS = 3;
endpackage

// >>> rtl/link_if.sv
// Purpose: Carries decoded instruction events from link to core domain
// Assumes: Toggle events, steady payload while toggle settles
// Notes: Core side synchronises toggles
`timescale 1ns/100ps
interface link_if;
	logic end_tgl;
	logic [7:0] end_op;
	logic end_exact;
	logic [2:0] busy_sync;
	logic sleep_lvl;
	modport link (output end_tgl, output end_op, output end_exact,
		input busy_sync, input sleep_lvl);
	modport core (input end_tgl, input end_op, input end_exact,
		output busy_sync, output sleep_lvl);
endinterface

// >>> rtl/spi_link_side.sv
// Purpose: Shift logic on the host's serial clock
// Assumes: Mode 0 style link; SCLK stops outside frames
// Notes: Reports opcode and whether frame ended exactly at bit 8
`timescale 1ns/100ps
module spi_link_side (
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic mosi_in,
	link_if.link lk,
	output logic miso_out,
	output logic miso_oe_out
);
	logic [5:0] bit_cnt_q;
	logic [7:0] op_q;
	logic [7:0] addr_q;
	logic [4:0] out_idx_q;
	logic [7:0] op_d;
	logic busy_s, sleep_s;
	assign op_d = {op_q[6:0], mosi_in};
	assign busy_s = lk.busy_sync[2];
	assign sleep_s = lk.sleep_lvl;
	// Frame-end toggle starts known; the core only watches its edges
	logic end_tgl_q = 1'b0;
	assign lk.end_tgl = end_tgl_q;

	// ----------------------------------------------------------------
	// Input sampling
	// ----------------------------------------------------------------
	// Rising edges collect opcode and count bits; deselect resets
	always_ff @(posedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			bit_cnt_q <= 6'h00;
		end else begin
			if (bit_cnt_q != 6'h3F) bit_cnt_q <= bit_cnt_q + 6'h01;
			if (bit_cnt_q < 6'h08) op_q <= op_d;
			else if (bit_cnt_q >= 6'h18 && bit_cnt_q < 6'h20)
				addr_q <= {addr_q[6:0], mosi_in};
		end
	end

	// Frame end report: toggle once per frame, exact when count is 8
	always_ff @(posedge cs_n_in) begin
		lk.end_op <= op_q;
		lk.end_exact <= (bit_cnt_q == 6'h08);
		end_tgl_q <= ~end_tgl_q;
	end

	// ----------------------------------------------------------------
	// Output shifting
	// ----------------------------------------------------------------
	logic [23:0] id_word;
	logic [7:0] short_a, short_b;
	logic [4:0] rel;
	logic [5:0] data_start;
	logic talking;
	assign short_a = (addr_q[0]) ? flash_cmd_pkg::SHORT_DEV_BYTE
		: flash_cmd_pkg::MAKER_BYTE;
	assign short_b = (addr_q[0]) ? flash_cmd_pkg::MAKER_BYTE
		: flash_cmd_pkg::SHORT_DEV_BYTE;
	assign data_start = (op_q == flash_cmd_pkg::READ_IDENTITY_ALIAS_OP) ? 6'h08 : 6'h20;
	// Identity is blocked while a cycle runs; only wake works in sleep
	assign talking = !busy_s && bit_cnt_q >= data_start && (
		(!sleep_s && op_q == flash_cmd_pkg::READ_IDENTITY_ALIAS_OP) ||
		(!sleep_s && op_q == flash_cmd_pkg::READ_SHORT_ID_OP
			&& bit_cnt_q >= 6'h20) ||
		op_q == flash_cmd_pkg::WAKE_SIG_OP);
	always_comb begin
		id_word = {flash_cmd_pkg::MAKER_BYTE, flash_cmd_pkg::MEM_TYPE_BYTE,
			flash_cmd_pkg::CAPACITY_BYTE};
		if (op_q == flash_cmd_pkg::READ_SHORT_ID_OP)
			id_word = {short_a, short_b, 8'h00};
		else if (op_q == flash_cmd_pkg::WAKE_SIG_OP)
			id_word = {3{flash_cmd_pkg::SIGNATURE_BYTE}};
	end
	assign rel = out_idx_q;

	// Falling edges drive data, MSB first; tristate when deselected
	always_ff @(negedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			miso_oe_out <= 1'b0;
			miso_out <= 1'b0;
			out_idx_q <= 5'h00;
		end else if (talking) begin
			miso_oe_out <= 1'b1;
			miso_out <= id_word[5'd23 - rel];
			if (op_q == flash_cmd_pkg::WAKE_SIG_OP)
				out_idx_q <= (rel == 5'd7) ? 5'd0 : rel + 5'd1;
			else if (rel != 5'd23)
				out_idx_q <= rel + 5'd1;
		end
	end
endmodule

// >>> test/spi_host_model.sv
// Purpose: Host end of the serial link: select, clock and data
// Assumes: Clock idles low; data changes while the clock is low
// Notes: Clock runs only inside frames; released data line flips
`timescale 1ns/100ps
module spi_host_model (
	output logic sclk_out,
	output logic cs_n_out,
	output logic mosi_out,
	input wire logic miso_in
);
	// ----------------------------------------------------------------
	// Idle levels
	// ----------------------------------------------------------------
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
	end
	// Frame: ntx bits of tx MSB first, then nrx bits into rx; select
	// rises only after the last clock, so frame length sets validity
	task automatic xfer(input logic [31:0] tx, input int ntx,
		input int nrx, output logic [31:0] rx);
		rx = 32'h0;
		cs_n_out = 1'b0;
		for (int i = ntx - 1; i >= 0; i--) begin
			mosi_out = tx[i];
			#16 sclk_out = 1'b1;
			#16 sclk_out = 1'b0;
		end
		// Sample late in the high phase: output is retimed internally
		for (int i = 0; i < nrx; i++) begin
			#16 sclk_out = 1'b1;
			#14 rx = {rx[30:0], miso_in};
			#2 sclk_out = 1'b0;
		end
		#16 cs_n_out = 1'b1;
		mosi_out = ~mosi_out;
		// Deselect gap well above the six-cycle minimum
		#200;
	endtask
endmodule

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the flash instruction interpreter
// Assumes: Host model clocks the link at a 32 ns period
// Notes: Erase, sleep and wake times shortened through parameters
`timescale 1ns/100ps
module tb_top;
	localparam int BE_CYC = 50;
	localparam int CE_CYC = 300;
	localparam int SL_CYC = 10;
	localparam int WK_CYC = 40;
	localparam logic [7:0] UNL = flash_cmd_pkg::WRITE_UNLOCK_OP;
	localparam logic [7:0] BER = flash_cmd_pkg::BLOCK_ERASE_OP;
	localparam logic [7:0] CER = flash_cmd_pkg::CHIP_ERASE_OP;
	localparam logic [7:0] SLP = flash_cmd_pkg::DEEP_SLEEP_OP;
	localparam logic [7:0] RID = flash_cmd_pkg::READ_IDENTITY_ALIAS_OP;
	localparam logic [7:0] SID = flash_cmd_pkg::READ_SHORT_ID_OP;
	localparam logic [7:0] MK = flash_cmd_pkg::MAKER_BYTE;
	localparam logic [7:0] DV = flash_cmd_pkg::SHORT_DEV_BYTE;
	logic clk, rst, sclk, cs_n, mosi, miso, miso_oe;
	logic write_enable_latch, write_in_progress_flag, sleep, be_done, ce_done, wip_prev, wel_at_fall;
	logic [2:0] protect;
	logic [31:0] rx, exp;
	int bad_count = 0;
	int checks = 0;
	int wip_cnt, be_cnt, ce_cnt, oe_cnt;
	wire miso_wire = miso_oe ? miso : 1'bz;
	// ----------------------------------------------------------------
	// Clock, design and host
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	flash_cmd_core #(.BLOCK_ERASE_CYCLES(BE_CYC),
		.CHIP_ERASE_CYCLES(CE_CYC), .SLEEP_CYCLES(SL_CYC),
		.WAKE_CYCLES(WK_CYC)) i_dut (.CLOCK_IN(clk), .RST_IN(rst),
		.SCLK_IN(sclk), .CS_N_IN(cs_n), .SERIAL_IN_LINE_IN(mosi),
		.PROTECT_FIELD_IN(protect), .SERIAL_OUT_OUT(miso),
		.SERIAL_OUT_OE_OUT(miso_oe), .WRITE_ENABLE_LATCH_OUT(write_enable_latch),
		.WRITE_IN_PROGRESS_FLAG_OUT(write_in_progress_flag), .DEEP_SLEEP_OUT(sleep),
		.BLOCK_ERASE_DONE_OUT(be_done), .CHIP_ERASE_DONE_OUT(ce_done));
	spi_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n),
		.mosi_out(mosi), .miso_in(miso_wire));
	// Event counters on the falling edge, where outputs are settled
	always @(negedge clk) begin
		wip_cnt += (write_in_progress_flag === 1'b1);
		be_cnt += (be_done === 1'b1);
		ce_cnt += (ce_done === 1'b1);
		oe_cnt += (miso_oe === 1'b1);
		if (wip_prev === 1'b1 && write_in_progress_flag === 1'b0) wel_at_fall = write_enable_latch;
		wip_prev = write_in_progress_flag;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] ex);
		checks++;
		if (seen !== ex) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, ex);
		end
	endtask
	task automatic clear();
		wip_cnt = 0;
		be_cnt = 0;
		ce_cnt = 0;
		oe_cnt = 0;
		wel_at_fall = 1'b1;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic op8(input logic [7:0] op);
		i_host.xfer({24'h0, op}, 8, 0, rx);
	endtask
	// Bounded wait for busy (sel 0) or sleep (sel 1) to reach v
	task automatic wait_lvl(input bit sel, input logic v, input int lim);
		int n = 0;
		while ((sel ? sleep : write_in_progress_flag) !== v && n < lim) begin
			cyc(1);
			n++;
		end
		check({31'h0, sel ? sleep : write_in_progress_flag}, {31'h0, v});
	endtask
	task automatic conclude();
		if (bad_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected run of about 33 us
	initial begin
		#500000;
		bad_count++;
		conclude();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		protect = 3'h0;
		wip_prev = 1'b0;
		clear();
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		cyc(2);
		check({28'h0, write_enable_latch, write_in_progress_flag, sleep, miso_oe}, 32'h0);
		// Erase without unlock, then bad frame lengths, are dropped
		op8(BER);
		op8(UNL);
		cyc(8);
		check({31'h0, write_enable_latch}, 32'h1);
		i_host.xfer({24'h0, BER} >> 1, 7, 0, rx);
		i_host.xfer({23'h0, BER, 1'b0}, 9, 0, rx);
		cyc(20);
		check(wip_cnt, 0);
		op8(BER);
		wait_lvl(0, 1'b0, BE_CYC + 20);
		cyc(2);
		check(wip_cnt >= BE_CYC && wip_cnt <= BE_CYC + 2, 1);
		check(be_cnt, 1);
		check({31'h0, wel_at_fall}, 32'h0);
		// Each nonzero protect field blocks block erase (odd values) or chip erase (even values)
		for (int p = 1; p < 8; p++) begin
			@(posedge clk) #1 protect = p[2:0];
			clear();
			op8(UNL);
			op8(p[0] ? BER : CER);
			cyc(20);
			check(wip_cnt + be_cnt + ce_cnt, 0);
		end
		@(posedge clk) #1 protect = 3'h0;
		// Chip erase with reads and sleep thrown in while busy
		clear();
		op8(UNL);
		op8(CER);
		i_host.xfer({24'h0, RID}, 8, 8, rx);
		op8(SLP);
		i_host.xfer({SID, 24'h1}, 32, 8, rx);
		check(oe_cnt, 0);
		check({31'h0, sleep}, 32'h0);
		wait_lvl(0, 1'b0, CE_CYC);
		cyc(2);
		check(wip_cnt >= CE_CYC && wip_cnt <= CE_CYC + 2, 1);
		check(ce_cnt, 1);
		check({31'h0, wel_at_fall}, 32'h0);
		// Identity reads: aborted one first, then full ones
		i_host.xfer({24'h0, RID}, 8, 4, rx);
		check(rx, {24'h0, MK} >> 4);
		check({31'h0, miso_oe}, 32'h0);
		i_host.xfer({24'h0, RID}, 8, 24, rx);
		exp = {8'h0, MK, flash_cmd_pkg::MEM_TYPE_BYTE,
			flash_cmd_pkg::CAPACITY_BYTE};
		check(rx, exp);
		for (int a = 0; a < 2; a++) begin
			i_host.xfer({SID, 16'h0, a[7:0]}, 32, 16, rx);
			exp = (a == 1) ? {16'h0, DV, MK} : {16'h0, MK, DV};
			check(rx, exp);
		end
		// Sleep: nine-bit frame refused, exact frame accepted
		i_host.xfer({23'h0, SLP, 1'b1}, 9, 0, rx);
		cyc(SL_CYC + 10);
		check({31'h0, sleep}, 32'h0);
		op8(SLP);
		wait_lvl(1, 1'b1, SL_CYC + 10);
		clear();
		op8(UNL);
		i_host.xfer({24'h0, RID}, 8, 8, rx);
		check({30'h0, write_enable_latch, oe_cnt != 0}, 32'h0);
		// Wake: three dummies, signature repeated, delayed standby
		i_host.xfer({flash_cmd_pkg::WAKE_SIG_OP, 24'h0}, 32, 16, rx);
		exp = {16'h0, {2{flash_cmd_pkg::SIGNATURE_BYTE}}};
		check(rx, exp);
		check({31'h0, sleep}, 32'h1);
		wait_lvl(1, 1'b0, WK_CYC + 10);
		op8(UNL);
		cyc(8);
		check({31'h0, write_enable_latch}, 32'h1);
		// Reset while asleep comes back in standby
		op8(SLP);
		wait_lvl(1, 1'b1, SL_CYC + 10);
		@(posedge clk) #1 rst = 1'b1;
		cyc(3);
		rst = 1'b0;
		cyc(2);
		check({30'h0, write_enable_latch, sleep}, 32'h0);
		cyc(SL_CYC + 10);
		check({31'h0, sleep}, 32'h0);
		conclude();
	end
endmodule
